/* File: bench/csp_codec_model.sv */
`timescale 1ns/10ps
module csp_codec_model (
  input  wire logic run,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  input  wire logic fsync
);
  logic [15:0]  word_q [0:15];
  logic [511:0] cap_out;
  logic [511:0] cap_oe;
  logic [511:0] cap_fs;
  int           slot_len;
  int           bitn;

  initial
  begin
    sck      = 1'b0;
    sdi      = 1'b0;
    bitn     = 0;
    slot_len = 16;
    for (int i = 0; i < 16; i++)
      word_q[i] = 16'hC35A ^ 16'(i * 16'h1F1F);
  end

  // Bit clock runs only while frames are wanted and stops low
  // Edges sit off the system clock edges; no rise once run has dropped
  always
  begin
    wait (run);
    #95;
    if (run)
    begin
      sck = 1'b1;
      if (bitn > 0 && bitn < 513)
      begin
        // The bit launched after the previous rise still stands here
        cap_out[bitn-1] = sdo;
        cap_oe[bitn-1]  = sdo_oe;
        cap_fs[bitn-1]  = fsync;
      end
      // New input bit after the rise, held across the sampling fall
      sdi  = word_q[(bitn / slot_len) % 16][15 - (bitn % slot_len)];
      bitn = bitn + 1;
      #100;
      sck = 1'b0;
    end
    #5;
  end

  // Outside frames the input line is not left at its last value
  always @(negedge run)
  begin
    bitn = 0;
    sdi  = ~sdi;
  end
endmodule

/* File: bench/csp_top_tb.sv */
`timescale 1ns/10ps
module csp_top_tb;
  import csp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, run;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, sck, sdi, sdo, sdo_oe, fsync, irq;
  int          err_count, compares, irq_n, base;

  csp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .serial_bit_clock(sck), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .frame_sync_line(fsync), .buffer_irq(irq));
  csp_codec_model codec_u (.run(run), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .fsync(fsync));

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (irq === 1'b1) irq_n <= irq_n + 1;

  task conclude();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task rchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    ahb(1'b0, a, 32'h00000000);
    chk(rd, exp, msg);
    chk(32'(hresp), 32'h00000000, "bus response not okay");
  endtask

  task wait_irq(input int n, input int lim);
    for (int k = 0; k < lim && irq_n < n; k++) @(posedge hclk);
    chk(32'(irq_n >= n), 32'h00000001, "buffer interrupt count");
  endtask

  task wait_bits(input int n, input int lim);
    for (int k = 0; k < lim && codec_u.bitn < n; k++) @(posedge hclk);
  endtask

  function automatic logic [15:0] sent(input int s, input int n);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < n; i++) w[15-i] = codec_u.cap_out[s+i];
    return w;
  endfunction

  task start(input logic [31:0] c1, input logic [31:0] c2, input logic [31:0] tm, input logic [31:0] rm);
    ahb(1'b1, CSP_OFS_CTRL2, c2);
    ahb(1'b1, CSP_OFS_TXMASK, tm);
    ahb(1'b1, CSP_OFS_RXMASK, rm);
    base = irq_n;
    ahb(1'b1, CSP_OFS_CTRL1, c1);
    wait_irq(base + 1, 8);
    run <= 1'b1;
  endtask

  task stop();
    run <= 1'b0;
    repeat (20) @(posedge hclk);
    ahb(1'b1, CSP_OFS_CTRL1, 32'h00000000);
  endtask

  task sc_regs();
    logic [11:0] regs [0:5];
    regs = '{CSP_OFS_CTRL1, CSP_OFS_CTRL2, CSP_OFS_TXMASK, CSP_OFS_RXMASK, CSP_OFS_TXW0, CSP_OFS_RXW0};
    for (int i = 0; i < 6; i++) rchk(regs[i], 32'h00000000, "reset value");
    ahb(1'b1, CSP_OFS_TXMASK, 32'hFFFF5A5A);
    rchk(CSP_OFS_TXMASK, 32'h00005A5A, "mask read back");
    ahb(1'b1, CSP_OFS_TXW0 + 12'h004, 32'h0000BEEF);
    rchk(CSP_OFS_TXW0 + 12'h004, 32'h0000BEEF, "transmit word read back");
    ahb(1'b1, CSP_OFS_RXW0 + 12'h004, 32'h00001234);
    rchk(CSP_OFS_RXW0 + 12'h004, 32'h00000000, "receive word is read only");
    ahb(1'b1, 12'h100, 32'h0000FFFF);
    rchk(12'h100, 32'h00000000, "unmapped address");
  endtask

  task sc_example();
    codec_u.slot_len = 8;
    ahb(1'b1, CSP_OFS_TXW0, 32'h0000A53C);
    ahb(1'b1, CSP_OFS_TXW0 + 12'h008, 32'h00005AC3);
    start(32'h00008000, 32'h00000C27, 32'h00000001, 32'h00000003);
    ahb(1'b1, CSP_OFS_TXW0 + 12'h008, 32'h0000FFFF);
    wait_irq(base + 2, 600);
    for (int k = 0; k < 4; k++)
      rchk(CSP_OFS_RXW0 + 12'(4 * k), {16'h0000, codec_u.word_q[k] & 16'hFF00}, "received word");
    chk(sent(0, 8), 16'hA500, "first slot data");
    chk(sent(8, 8), 16'h0000, "disabled slot drives zero");
    chk(codec_u.cap_oe[8 +: 8], 8'hFF, "disabled slot still driven");
    chk(sent(16, 8), 16'h5A00, "third buffer word");
    chk({codec_u.cap_fs[17:15], codec_u.cap_fs[1:0]}, 5'b01001, "frame sync position");
    stop();
  endtask

  task sc_idle();
    codec_u.slot_len = 16;
    ahb(1'b1, CSP_OFS_TXW0, 32'h00001357);
    start(32'h00008040, 32'h0000004F, 32'h00008005, 32'h00000002);
    rchk(CSP_OFS_RXW0, 32'h00000000, "receive word after enable");
    wait_irq(base + 2, 300);
    rchk(CSP_OFS_RXW0, 32'h00000000, "disabled receive slot");
    wait_irq(base + 3, 300);
    rchk(CSP_OFS_RXW0, {16'h0000, codec_u.word_q[1]}, "enabled receive slot");
    wait_bits(50, 600);
    chk(sent(0, 16), 16'h1357, "full word msb first");
    chk(codec_u.cap_oe[16 +: 16], 16'h0000, "float in disabled slot");
    chk(sent(32, 16), 16'h1357, "single word buffer reload");
    chk({codec_u.cap_fs[48:47], codec_u.cap_fs[32], codec_u.cap_fs[16], codec_u.cap_fs[0]},
      5'b10001, "three slot frame");
    stop();
  endtask

  task sc_modes();
    int per;
    codec_u.slot_len = 4;
    for (int p = 0; p < 4; p++)
    begin
      per = (p >= 2) ? 256 : 8;
      start(32'h00008000 | 32'(p), 32'h00000023, 32'h00000001, 32'h00000000);
      wait_bits(per + 2, per * 8 + 100);
      chk({codec_u.cap_fs[per], codec_u.cap_fs[per-1], codec_u.cap_fs[0]}, 3'b101, "frame period");
      stop();
    end
  endtask

  initial
  begin
    hclk      = 1'b0;
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h00000000;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h00000000;
    run       = 1'b0;
    err_count = 0;
    compares  = 0;
    irq_n     = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sc_regs();
    sc_example();
    sc_idle();
    sc_modes();
    conclude();
  end

  initial
  begin
    #1000000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule

/* File: hw/csp_pkg.sv */
package csp_pkg;

  // Register byte offsets
  localparam logic [11:0] CSP_OFS_CTRL1  = 12'h000;
  localparam logic [11:0] CSP_OFS_CTRL2  = 12'h004;
  localparam logic [11:0] CSP_OFS_STATUS = 12'h008;
  localparam logic [11:0] CSP_OFS_TXMASK = 12'h00C;
  localparam logic [11:0] CSP_OFS_RXMASK = 12'h010;
  localparam logic [11:0] CSP_OFS_TXW0   = 12'h020;
  localparam logic [11:0] CSP_OFS_RXW0   = 12'h030;

  // Field positions
  localparam int unsigned CSP_C1_EN_POS   = 15;
  localparam int unsigned CSP_C1_IDLE_POS = 6;
  localparam int unsigned CSP_C1_PROT_LSB = 0;
  localparam int unsigned CSP_C2_WS_LSB   = 0;
  localparam int unsigned CSP_C2_FL_LSB   = 5;
  localparam int unsigned CSP_C2_BL_LSB   = 10;

  // Reset values
  localparam logic [15:0] CSP_CTRL1_RST = 16'h0000;
  localparam logic [15:0] CSP_CTRL2_RST = 16'h0000;
  localparam logic [15:0] CSP_MASK_RST  = 16'h0000;
  localparam logic [15:0] CSP_WORD_RST  = 16'h0000;

  // Timing counts
  localparam logic [1:0]  CSP_STARTUP_CYCLES = 2'h3;
  localparam logic [4:0]  CSP_AC_SLOT_BITS   = 5'h10;
  localparam logic [4:0]  CSP_AC_SLOTS       = 5'h10;

  typedef enum logic [1:0] {
    CSP_MULTI,
    CSP_I2S,
    CSP_AC16,
    CSP_AC20
  } csp_proto_t;

  typedef enum logic [1:0] {
    CSP_OFF,
    CSP_START,
    CSP_RUN
  } csp_state_t;

  typedef struct packed {
    logic       enable;
    logic       idle_mode;
    csp_proto_t proto;
  } csp_ctrl1_t;

  typedef struct packed {
    logic [1:0] buf_len;
    logic [3:0] frame_len;
    logic [3:0] word_size;
  } csp_ctrl2_t;

endpackage

/* File: hw/csp_top.sv */
`timescale 1ns/10ps
module csp_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        serial_bit_clock,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             frame_sync_line,
  output logic             buffer_irq
);
  import csp_pkg::*;

  csp_ctrl1_t  ctrl1_r;
  csp_ctrl2_t  ctrl2_r;
  logic [15:0] tx_mask_r;
  logic [15:0] rx_mask_r;
  logic [15:0] vis_tx_r [4];
  logic [15:0] vis_rx_r [4];
  logic [15:0] buf_tx_r [4];
  logic [15:0] buf_rx_r [4];
  logic        sck_s1_r;
  logic        sck_s2_r;
  logic        sck_s3_r;
  logic        din_s1_r;
  logic        din_s2_r;
  logic        wr_pend_r;
  logic [11:0] wr_addr_r;
  logic        rd_pend_r;
  logic [11:0] rd_addr_r;
  csp_state_t  state_r;
  logic [1:0]  start_cnt_r;
  logic        started_r;
  logic [3:0]  bit_r;
  logic [3:0]  slot_r;
  logic [1:0]  ptr_r;
  logic [15:0] tx_sh_r;
  logic [15:0] rx_sh_r;
  logic [15:0] rx_nxt;
  logic [4:0]  wlen;
  logic [4:0]  nslots;
  logic [15:0] lj_mask;
  logic        ac_mode;
  logic        rise;
  logic        fall;
  logic        fall_act;
  logic        slot_end;
  logic        frame_end;
  logic        store;
  logic        wrap;
  logic        start_done;
  logic        xfer;
  logic        tx_active;
  logic        fs_nxt;
  logic [31:0] rd_mux;

  // Two-stage synchronisers; third stage only for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end
    else
    begin
      sck_s1_r <= serial_bit_clock;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      din_s1_r <= serial_data_in;
      din_s2_r <= din_s1_r;
    end
  end

  assign rise = sck_s2_r & ~sck_s3_r;
  assign fall = ~sck_s2_r & sck_s3_r;

  // Frame geometry
  assign ac_mode = (ctrl1_r.proto == CSP_AC16) || (ctrl1_r.proto == CSP_AC20);
  assign wlen    = ac_mode ? CSP_AC_SLOT_BITS : {1'b0, ctrl2_r.word_size} + 5'h01;
  assign nslots  = ac_mode ? CSP_AC_SLOTS : {1'b0, ctrl2_r.frame_len} + 5'h01;
  assign lj_mask = 16'hFFFF << (5'h10 - wlen);

  // AHB-Lite slave: writes zero-wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      rd_pend_r <= 1'b0;
      rd_addr_r <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= 1'b0;
      if (rd_pend_r)
      begin
        hrdata    <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend_r <= 1'b0;
      end
      else if (hsel && htrans[1] && hready)
      begin
        if (hwrite)
        begin
          wr_pend_r <= 1'b1;
          wr_addr_r <= haddr[11:0];
        end
        else
        begin
          rd_pend_r <= 1'b1;
          rd_addr_r <= haddr[11:0];
          hreadyout <= 1'b0;
        end
      end
    end
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr_r)
      CSP_OFS_CTRL1:  rd_mux[15:0] = {ctrl1_r.enable, 8'h00, ctrl1_r.idle_mode, 4'h0, ctrl1_r.proto};
      CSP_OFS_CTRL2:  rd_mux[15:0] = {4'h0, ctrl2_r.buf_len, 1'b0, ctrl2_r.frame_len, 1'b0, ctrl2_r.word_size};
      CSP_OFS_STATUS: rd_mux[15:0] = {2'h0, state_r == CSP_RUN, started_r, ptr_r, slot_r, bit_r, 2'h0};
      CSP_OFS_TXMASK: rd_mux[15:0] = tx_mask_r;
      CSP_OFS_RXMASK: rd_mux[15:0] = rx_mask_r;
      CSP_OFS_TXW0:         rd_mux[15:0] = vis_tx_r[0];
      CSP_OFS_TXW0 + 12'h4: rd_mux[15:0] = vis_tx_r[1];
      CSP_OFS_TXW0 + 12'h8: rd_mux[15:0] = vis_tx_r[2];
      CSP_OFS_TXW0 + 12'hC: rd_mux[15:0] = vis_tx_r[3];
      CSP_OFS_RXW0:         rd_mux[15:0] = vis_rx_r[0];
      CSP_OFS_RXW0 + 12'h4: rd_mux[15:0] = vis_rx_r[1];
      CSP_OFS_RXW0 + 12'h8: rd_mux[15:0] = vis_rx_r[2];
      CSP_OFS_RXW0 + 12'hC: rd_mux[15:0] = vis_rx_r[3];
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Software-written registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl1_r   <= csp_ctrl1_t'({CSP_CTRL1_RST[CSP_C1_EN_POS], CSP_CTRL1_RST[CSP_C1_IDLE_POS],
                                 CSP_CTRL1_RST[CSP_C1_PROT_LSB +: 2]});
      ctrl2_r   <= csp_ctrl2_t'({CSP_CTRL2_RST[CSP_C2_BL_LSB +: 2], CSP_CTRL2_RST[CSP_C2_FL_LSB +: 4],
                                 CSP_CTRL2_RST[CSP_C2_WS_LSB +: 4]});
      tx_mask_r <= CSP_MASK_RST;
      rx_mask_r <= CSP_MASK_RST;
      for (int i = 0; i < 4; i++)
        vis_tx_r[i] <= CSP_WORD_RST;
    end
    else if (wr_pend_r)
    begin
      if (wr_addr_r == CSP_OFS_CTRL1)
      begin
        ctrl1_r.enable    <= hwdata[CSP_C1_EN_POS];
        ctrl1_r.idle_mode <= hwdata[CSP_C1_IDLE_POS];
        ctrl1_r.proto     <= csp_proto_t'(hwdata[CSP_C1_PROT_LSB +: 2]);
      end
      if (wr_addr_r == CSP_OFS_CTRL2)
      begin
        ctrl2_r.word_size <= hwdata[CSP_C2_WS_LSB +: 4];
        ctrl2_r.frame_len <= hwdata[CSP_C2_FL_LSB +: 4];
        ctrl2_r.buf_len   <= hwdata[CSP_C2_BL_LSB +: 2];
      end
      if (wr_addr_r == CSP_OFS_TXMASK)
        tx_mask_r <= hwdata[15:0];
      if (wr_addr_r == CSP_OFS_RXMASK)
        rx_mask_r <= hwdata[15:0];
      for (int i = 0; i < 4; i++)
        if (wr_addr_r == CSP_OFS_TXW0 + 12'(4 * i))
          vis_tx_r[i] <= hwdata[15:0];
    end
  end

  // Enable sequencing
  assign start_done = (state_r == CSP_START) && (start_cnt_r == CSP_STARTUP_CYCLES - 2'h1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r     <= CSP_OFF;
      start_cnt_r <= 2'h0;
    end
    else if (!ctrl1_r.enable)
    begin
      state_r     <= CSP_OFF;
      start_cnt_r <= 2'h0;
    end
    else
    begin
      unique case (state_r)
        CSP_OFF:
          state_r <= CSP_START;
        CSP_START:
        begin
          start_cnt_r <= start_cnt_r + 2'h1;
          if (start_done)
            state_r <= CSP_RUN;
        end
        CSP_RUN:
          state_r <= CSP_RUN;
      endcase
    end
  end

  // Serial engine: drive on bit clock rise, sample and count on fall
  assign fall_act  = fall && started_r && (state_r == CSP_RUN) && ctrl1_r.enable;
  assign slot_end  = fall_act && ({1'b0, bit_r} == wlen - 5'h01);
  assign frame_end = slot_end && ({1'b0, slot_r} == nslots - 5'h01);
  assign store     = slot_end && rx_mask_r[slot_r];
  assign wrap      = slot_end && (ptr_r == ctrl2_r.buf_len);
  assign xfer      = start_done || wrap;
  assign tx_active = tx_mask_r[slot_r];

  always_comb
  begin
    rx_nxt = rx_sh_r;
    rx_nxt[4'hF - bit_r] = din_s2_r;
  end

  always_comb
  begin
    unique case (ctrl1_r.proto)
      CSP_MULTI: fs_nxt = (slot_r == 4'h0) && (bit_r == 4'h0);
      CSP_I2S:   fs_nxt = ~slot_r[0];
      CSP_AC16,
      CSP_AC20:  fs_nxt = (slot_r == 4'h0);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      started_r <= 1'b0;
      bit_r     <= 4'h0;
      slot_r    <= 4'h0;
      rx_sh_r   <= 16'h0000;
    end
    else if ((state_r != CSP_RUN) || !ctrl1_r.enable)
    begin
      started_r <= 1'b0;
      bit_r     <= 4'h0;
      slot_r    <= 4'h0;
      rx_sh_r   <= 16'h0000;
    end
    else
    begin
      if (rise)
        started_r <= 1'b1;
      if (fall_act)
      begin
        rx_sh_r <= slot_end ? 16'h0000 : rx_nxt;
        bit_r   <= slot_end ? 4'h0 : bit_r + 4'h1;
        if (frame_end)
          slot_r <= 4'h0;
        else if (slot_end)
          slot_r <= slot_r + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_sh_r            <= 16'h0000;
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
      frame_sync_line    <= 1'b0;
    end
    else if (state_r != CSP_RUN)
    begin
      tx_sh_r            <= 16'h0000;
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
      frame_sync_line    <= 1'b0;
    end
    else if (rise)
    begin
      frame_sync_line    <= fs_nxt;
      serial_data_out_oe <= tx_active | ~ctrl1_r.idle_mode;
      if (bit_r == 4'h0)
      begin
        tx_sh_r         <= (buf_tx_r[ptr_r] & lj_mask) << 1;
        serial_data_out <= tx_active & buf_tx_r[ptr_r][15];
      end
      else
      begin
        tx_sh_r         <= tx_sh_r << 1;
        serial_data_out <= tx_active & tx_sh_r[15];
      end
    end
  end

  // Buffer control: one pointer for both directions
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ptr_r <= 2'h0;
    else if ((state_r != CSP_RUN) || !ctrl1_r.enable)
      ptr_r <= 2'h0;
    else if (slot_end)
      ptr_r <= wrap ? 2'h0 : ptr_r + 2'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        buf_tx_r[i] <= CSP_WORD_RST;
        buf_rx_r[i] <= CSP_WORD_RST;
        vis_rx_r[i] <= CSP_WORD_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!ctrl1_r.enable)
          buf_rx_r[i] <= CSP_WORD_RST;
        else if (store && (ptr_r == 2'(i)))
          buf_rx_r[i] <= rx_nxt & lj_mask;
        if (xfer)
        begin
          buf_tx_r[i] <= vis_tx_r[i];
          vis_rx_r[i] <= (store && (ptr_r == 2'(i))) ? (rx_nxt & lj_mask) : buf_rx_r[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      buffer_irq <= 1'b0;
    else
      buffer_irq <= xfer;
  end

  // Helper for frame length check
  logic [9:0] frm_cnt_r;
  logic       frm_seen_r;
  logic       frm_start;
  assign frm_start = rise && (state_r == CSP_RUN) && (slot_r == 4'h0) && (bit_r == 4'h0);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frm_cnt_r  <= 10'h000;
      frm_seen_r <= 1'b0;
    end
    else if (state_r != CSP_RUN)
    begin
      frm_cnt_r  <= 10'h000;
      frm_seen_r <= 1'b0;
    end
    else if (rise)
    begin
      frm_cnt_r  <= frm_start ? 10'h001 : frm_cnt_r + 10'h001;
      frm_seen_r <= frm_seen_r | frm_start;
    end
  end

  a_frame_length: assert property (@(posedge hclk) disable iff (!hresetn)
    frm_start && frm_seen_r |-> frm_cnt_r == ({5'h00, wlen} * {5'h00, nslots}))
    else $error("frame length differs from slot size times slot count");
  a_ac_frame: assert property (@(posedge hclk) disable iff (!hresetn)
    frm_start && frm_seen_r && ac_mode |-> frm_cnt_r == 10'h100)
    else $error("AC-Link frame not 256 bit clocks");
  a_ptr_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    wrap |=> ptr_r == 2'h0 && buffer_irq)
    else $error("pointer not reset with interrupt at buffer end");
  a_rx_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    store |=> (buf_rx_r[$past(ptr_r)] & ~$past(lj_mask)) == 16'h0000)
    else $error("received word low bits not zero");
  a_idle_float: assert property (@(posedge hclk) disable iff (!hresetn)
    rise && state_r == CSP_RUN && !tx_active |=> serial_data_out == 1'b0 &&
    serial_data_out_oe == !$past(ctrl1_r.idle_mode))
    else $error("disabled slot output not zero or float");
  a_disable_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl1_r.enable |=> ptr_r == 2'h0 && slot_r == 4'h0 && bit_r == 4'h0 && state_r == CSP_OFF)
    else $error("counters not reset on disable");
  a_start_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_r == CSP_START) ##1 ctrl1_r.enable [*2] |=> buffer_irq)
    else $error("first interrupt not three cycles after enable");
  a_rx_zero_start: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state_r == CSP_RUN) |-> vis_rx_r[0] == 16'h0000 && vis_rx_r[3] == 16'h0000)
    else $error("receive words not zero after enable");
  a_tx_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == CSP_RUN && !$past(rise) && $past(state_r == CSP_RUN) |-> $stable(tx_sh_r))
    else $error("shift register changed outside bit clock edge");
  a_slot_zero_fs: assert property (@(posedge hclk) disable iff (!hresetn)
    rise && state_r == CSP_RUN && ctrl1_r.proto == CSP_MULTI |=>
    frame_sync_line == ($past(slot_r) == 4'h0 && $past(bit_r) == 4'h0))
    else $error("frame sync not at first bit of slot zero");

  c_buffer_wrap:  cover property (@(posedge hclk) disable iff (!hresetn) wrap);
  c_frame_end:    cover property (@(posedge hclk) disable iff (!hresetn) frame_end);
  c_rx_store:     cover property (@(posedge hclk) disable iff (!hresetn) store && ptr_r == 2'h3);
  c_bus_read:     cover property (@(posedge hclk) disable iff (!hresetn) rd_pend_r ##1 hreadyout);

endmodule
